// [src/swps_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface swps_link_if;
  import swps_pkg::*;

  logic                 active;
  logic [1:0]           fmt;
  logic [NUM_CH-1:0]    slot_en;
  logic [FRAME_W-1:0]   data;
  logic                 tog;

  modport core (output active, output fmt, output slot_en, output data, output tog);
  modport link (input active, input fmt, input slot_en, input data, input tog);
endinterface
`default_nettype wire

// [src/swps_pkg.sv]
package swps_pkg;

  // Core clock and documented waits
  localparam int CORE_CLK_MHZ     = 25;
  localparam int INIT_TIME_US     = 1000;
  localparam int WAKE_TIME_US     = 1000;
  localparam int SHUTDOWN_TIME_US = 6000;
  localparam int INIT_CYCLES      = INIT_TIME_US * CORE_CLK_MHZ;
  localparam int WAKE_CYCLES      = WAKE_TIME_US * CORE_CLK_MHZ;
  localparam int SHUTDOWN_CYCLES  = SHUTDOWN_TIME_US * CORE_CLK_MHZ;
  localparam int CNT_W            = 18;

  // Channel and slot layout
  localparam int NUM_CH    = 2;
  localparam int WORD_W    = 32;
  localparam int FRAME_W   = NUM_CH * WORD_W;
  localparam int BITCNT_W  = 6;

  // Power-up control field positions
  localparam int PWR_ADC_BIT  = 0;
  localparam int PWR_BIAS_BIT = 1;
  localparam int PWR_PLL_BIT  = 2;

  // Device status field positions
  localparam int STAT_DONE_BIT  = 7;
  localparam int STAT_AWAKE_BIT = 0;

  // Reset values of the configuration
  localparam logic [1:0] IN_EN_RST  = 2'h0;
  localparam logic [1:0] SLOT_EN_RST = 2'h0;
  localparam logic [2:0] PWR_RST    = 3'h0;

  typedef enum logic [1:0] {
    FMT_TDM,
    FMT_I2S,
    FMT_LJ
  } swps_fmt_e;

  typedef enum logic [2:0] {
    ST_INIT,
    ST_SLEEP,
    ST_WAKING,
    ST_AWAKE,
    ST_SHUTDOWN
  } swps_state_e;

endpackage

// [src/swps_tdm_tx.sv]
`timescale 1ns/1ps
`default_nettype none
module swps_tdm_tx
  import swps_pkg::*;
(
  // Link clock and frame
  input  wire logic    bit_clk_i,
  input  wire logic    rst_i,
  input  wire logic    frame_sync_i,
  // Core side
  swps_link_if.link    lk,
  // Serial data pin
  output logic         sdout_o,
  output logic         sdout_oe_o
);
  import swps_pkg::*;

  typedef struct packed {
    logic                rst_s1;
    logic                rst_s2;
    logic                act_s1;
    logic                act_s2;
    logic [1:0]          fmt_s1;
    logic [1:0]          fmt_s2;
    logic [NUM_CH-1:0]   slot_s1;
    logic [NUM_CH-1:0]   slot_s2;
    logic                tog_s1;
    logic                tog_s2;
    logic                tog_s3;
    logic [FRAME_W-1:0]  hold;
    logic [FRAME_W-1:0]  shreg;
    logic [BITCNT_W-1:0] cnt;
    logic                run;
    logic                fs_d;
    logic                pend;
    logic                sdo;
    logic                oe;
  } swps_link_s;

  swps_link_s q;
  swps_link_s nxt;
  logic       load;

  always_comb begin
    nxt         = q;
    nxt.rst_s1  = rst_i;
    nxt.rst_s2  = q.rst_s1;
    nxt.act_s1  = lk.active;
    nxt.act_s2  = q.act_s1;
    nxt.fmt_s1  = lk.fmt;
    nxt.fmt_s2  = q.fmt_s1;
    nxt.slot_s1 = lk.slot_en;
    nxt.slot_s2 = q.slot_s1;
    nxt.tog_s1  = lk.tog;
    nxt.tog_s2  = q.tog_s1;
    nxt.tog_s3  = q.tog_s2;
    nxt.fs_d    = frame_sync_i;
    // Word is stable on the core side long before the toggle arrives here
    if (q.tog_s2 != q.tog_s3) begin
      nxt.hold = lk.data;
    end
    // I2S frames start one bit after the falling edge; TDM and LJ on the rising edge
    nxt.pend = q.fs_d & ~frame_sync_i;
    if (q.fmt_s2 == FMT_I2S) begin
      load = q.pend;
    end else begin
      load = ~q.fs_d & frame_sync_i;
    end
    if (load) begin
      nxt.sdo   = q.hold[FRAME_W-1];
      nxt.oe    = q.slot_s2[0];
      nxt.shreg = {q.hold[FRAME_W-2:0], 1'b0};
      nxt.cnt   = BITCNT_W'(1);
      nxt.run   = 1'b1;
    end else if (q.run) begin
      nxt.sdo   = q.shreg[FRAME_W-1];
      nxt.oe    = q.slot_s2[q.cnt[BITCNT_W-1]];
      nxt.shreg = {q.shreg[FRAME_W-2:0], 1'b0};
      nxt.cnt   = q.cnt + BITCNT_W'(1);
      nxt.run   = (q.cnt != '0);
      if (q.cnt == '0) begin
        nxt.oe  = 1'b0;
        nxt.sdo = 1'b0;
      end
    end
    // Idle and deaf to frame edges unless awake and powered
    if (q.rst_s2 || !q.act_s2) begin
      nxt.run   = 1'b0;
      nxt.oe    = 1'b0;
      nxt.sdo   = 1'b0;
      nxt.cnt   = '0;
      nxt.pend  = 1'b0;
      nxt.shreg = '0;
    end
  end

  always_ff @(posedge bit_clk_i) begin
    q <= nxt;
  end

  assign sdout_o    = q.sdo;
  assign sdout_oe_o = q.oe;

  a_link_idle: assert property (@(posedge bit_clk_i) disable iff (q.rst_s2)
    !q.act_s2 |=> !sdout_oe_o && !q.run)
    else $error("serial output driven while inactive");

  a_frame_run: assert property (@(posedge bit_clk_i) disable iff (q.rst_s2 || !q.act_s2)
    $rose(q.run) |-> q.run [*8] ##0 (q.cnt == BITCNT_W'(8)))
    else $error("frame stopped early");

endmodule
`default_nettype wire

// [src/swps_top.sv]
`timescale 1ns/1ps
`default_nettype none
module swps_top
#(
  parameter int INIT_CYC = swps_pkg::INIT_CYCLES,
  parameter int WAKE_CYC = swps_pkg::WAKE_CYCLES,
  parameter int SHUT_CYC = swps_pkg::SHUTDOWN_CYCLES
) (
  // Core clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_i,
  // Control port writes
  input  wire logic                         sleep_ctrl_wr_i,
  input  wire logic                         sleep_mode_i,
  input  wire logic                         cfg_wr_i,
  input  wire logic [swps_pkg::NUM_CH-1:0] input_channel_enable_i,
  input  wire logic [swps_pkg::NUM_CH-1:0] output_slot_enable_i,
  input  wire logic [2:0]                   power_up_control_i,
  input  wire logic [1:0]                   serial_format_i,
  // Recorded samples
  input  wire logic                         sample_valid_i,
  input  wire logic [swps_pkg::WORD_W-1:0] ch1_sample_i,
  input  wire logic [swps_pkg::WORD_W-1:0] ch2_sample_i,
  // Status and power
  output logic [7:0]                        device_status_o,
  output logic                              shutdown_done_o,
  output logic                              adc_on_o,
  output logic                              mic_bias_supply_on_o,
  output logic                              pll_on_o,
  output logic                              vol_ramp_o,
  // Audio serial link
  input  wire logic                         bit_clk_i,
  input  wire logic                         frame_sync_i,
  output logic                              sdout_o,
  output logic                              sdout_oe_o
);
  import swps_pkg::*;

  typedef struct packed {
    swps_state_e        st;
    logic [CNT_W-1:0]   cnt;
    logic [NUM_CH-1:0]  in_en;
    logic [NUM_CH-1:0]  slot_en;
    logic [2:0]         pwr;
    logic [1:0]         fmt;
    logic               done;
    logic [FRAME_W-1:0] dat;
    logic               tog;
  } swps_core_s;

  swps_core_s q;
  swps_core_s nxt;
  logic       link_active;

  swps_link_if lk ();

  always_comb begin
    nxt = q;
    // Configuration is taken whenever initialisation is over and never cleared by sleep
    if (cfg_wr_i && q.st != ST_INIT) begin
      nxt.in_en   = input_channel_enable_i;
      nxt.slot_en = output_slot_enable_i;
      nxt.pwr     = power_up_control_i;
      nxt.fmt     = serial_format_i;
    end
    case (q.st)
      ST_INIT: begin
        nxt.cnt = q.cnt + CNT_W'(1);
        if (q.cnt == CNT_W'(INIT_CYC - 1)) begin
          nxt.st   = ST_SLEEP;
          nxt.cnt  = '0;
          nxt.done = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (sleep_ctrl_wr_i && !sleep_mode_i) begin
          nxt.st   = ST_WAKING;
          nxt.cnt  = '0;
          nxt.done = 1'b0;
        end
      end
      ST_WAKING: begin
        nxt.cnt = q.cnt + CNT_W'(1);
        if (sleep_ctrl_wr_i && sleep_mode_i) begin
          nxt.st  = ST_SHUTDOWN;
          nxt.cnt = '0;
        end else if (q.cnt == CNT_W'(WAKE_CYC - 1)) begin
          nxt.st  = ST_AWAKE;
          nxt.cnt = '0;
        end
      end
      ST_AWAKE: begin
        if (sleep_ctrl_wr_i && sleep_mode_i) begin
          nxt.st  = ST_SHUTDOWN;
          nxt.cnt = '0;
        end
      end
      ST_SHUTDOWN: begin
        nxt.cnt = q.cnt + CNT_W'(1);
        if (q.cnt == CNT_W'(SHUT_CYC - 1)) begin
          nxt.st   = ST_SLEEP;
          nxt.cnt  = '0;
          nxt.done = 1'b1;
        end
      end
      default: begin
        nxt.st  = ST_INIT;
        nxt.cnt = '0;
      end
    endcase
    // Disabled input channels record silence
    if (sample_valid_i && link_active) begin
      nxt.dat = {ch1_sample_i & {WORD_W{q.in_en[0]}}, ch2_sample_i & {WORD_W{q.in_en[1]}}};
      nxt.tog = ~q.tog;
    end
    if (rst_i) begin
      nxt.st      = ST_INIT;
      nxt.cnt     = '0;
      nxt.in_en   = IN_EN_RST;
      nxt.slot_en = SLOT_EN_RST;
      nxt.pwr     = PWR_RST;
      nxt.fmt     = FMT_TDM;
      nxt.done    = 1'b0;
      nxt.dat     = '0;
      nxt.tog     = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    q <= nxt;
  end

  assign link_active = (q.st == ST_AWAKE) && q.pwr[PWR_ADC_BIT];

  assign lk.active  = link_active;
  assign lk.fmt     = q.fmt;
  assign lk.slot_en = q.slot_en;
  assign lk.data    = q.dat;
  assign lk.tog     = q.tog;

  always_comb begin
    device_status_o                 = 8'h00;
    device_status_o[STAT_DONE_BIT]  = q.done;
    device_status_o[STAT_AWAKE_BIT] = (q.st == ST_AWAKE);
  end

  assign shutdown_done_o      = q.done;
  assign adc_on_o             = (q.st == ST_AWAKE) && q.pwr[PWR_ADC_BIT];
  assign mic_bias_supply_on_o = (q.st == ST_AWAKE) && q.pwr[PWR_BIAS_BIT];
  assign pll_on_o             = (q.st == ST_AWAKE) && q.pwr[PWR_PLL_BIT];
  assign vol_ramp_o           = (q.st == ST_SHUTDOWN);

  swps_tdm_tx u_tx (
    .bit_clk_i    (bit_clk_i),
    .rst_i        (rst_i),
    .frame_sync_i (frame_sync_i),
    .lk           (lk),
    .sdout_o      (sdout_o),
    .sdout_oe_o   (sdout_oe_o)
  );

  a_init_sleep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q.st == ST_INIT && q.cnt == CNT_W'(INIT_CYC - 1)) |=> (q.st == ST_SLEEP) && shutdown_done_o && !adc_on_o)
    else $error("initialisation did not end in sleep");

  a_wake_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q.st == ST_AWAKE && $past(q.st) == ST_WAKING) |-> $past(q.cnt) == CNT_W'(WAKE_CYC - 1))
    else $error("wake sequence ended at wrong count");

  a_done_cause: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(shutdown_done_o) |-> $past(q.st) inside {ST_INIT, ST_SHUTDOWN})
    else $error("shutdown flag set without shutdown");

  a_done_sleep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    shutdown_done_o |-> (q.st == ST_SLEEP) && !pll_on_o && !mic_bias_supply_on_o)
    else $error("shutdown flag set while not asleep");

  a_sleep_keep: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (q.st == ST_SHUTDOWN && !cfg_wr_i) |=> $stable(q.in_en) && $stable(q.slot_en) && $stable(q.pwr))
    else $error("configuration lost on sleep entry");

  a_cfg_take: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (cfg_wr_i && q.st != ST_INIT) |=> q.slot_en == $past(output_slot_enable_i))
    else $error("configuration write not taken");

  a_link_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !lk.active |=> $stable(lk.tog) && $stable(lk.data))
    else $error("sample handed to link while asleep or unpowered");

  a_sample_cap: assert property (@(posedge core_clk_i) disable iff (rst_i)
    (sample_valid_i && lk.active) |=> (lk.tog != $past(lk.tog)) ##0 (lk.data[WORD_W-1:0] ==
      ($past(ch2_sample_i) & {WORD_W{$past(q.in_en[1])}})))
    else $error("sample not handed to link");

  a_ramp_len: assert property (@(posedge core_clk_i) disable iff (rst_i)
    $rose(vol_ramp_o) |-> vol_ramp_o [*8])
    else $error("volume ramp cut short");

endmodule
`default_nettype wire

// [tb/swps_host_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module swps_host_link_model #(
  parameter realtime HALF = 62.5
) (
  // Frame request from the bench
  input  wire logic        go_i,
  input  wire logic        i2s_i,
  // Serial pins
  input  wire logic        sdout_i,
  input  wire logic        sdout_oe_i,
  output logic             bit_clk_o,
  output logic             frame_sync_o,
  // Captured frame
  output logic [63:0]      frame_o,
  output logic [63:0]      oe_map_o,
  output int               n_oe_o,
  output logic             oe_after_o,
  output logic             done_o
);
  initial begin
    bit_clk_o    = 1'b0;
    frame_sync_o = 1'b0;
    frame_o      = '0;
    oe_map_o     = '0;
    n_oe_o       = 0;
    oe_after_o   = 1'b0;
    done_o       = 1'b0;
    forever begin
      // Clocks stand still until the host asks for a frame
      @(posedge go_i);
      n_oe_o = 0;
      for (int i = 0; i < 72; i++) begin
        // I2S sync falls one bit ahead of data; it rises late enough for the link to settle its format
        frame_sync_o = i2s_i ? (i >= 2 && i < 4) : (i == 4);
        #(HALF) bit_clk_o = 1'b1;
        #(HALF) bit_clk_o = 1'b0;
        if (i >= 4 + int'(i2s_i) && i < 68 + int'(i2s_i)) begin
          frame_o  = {frame_o[62:0], sdout_i};
          oe_map_o = {oe_map_o[62:0], sdout_oe_i};
          n_oe_o   = n_oe_o + ((sdout_oe_i === 1'b0) ? 0 : 1);
        end
      end
      oe_after_o = sdout_oe_i;
      done_o     = ~done_o;
    end
  end
endmodule
`default_nettype wire

// [tb/test_sleep_wake_power_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end
module test_sleep_wake_power_sequencer;
  import swps_pkg::*;
  localparam int INIT = 20;
  localparam int WAKE = 20;
  localparam int SHUT = 40;
  logic              core_clk_i = 1'b0;
  logic              rst_i = 1'b1;
  logic              sleep_ctrl_wr_i = 1'b0;
  logic              sleep_mode_i = 1'b0;
  logic              cfg_wr_i = 1'b0;
  logic [1:0]        ie_r = 2'h0;
  logic [1:0]        se_r = 2'h0;
  logic [2:0]        pw_r = 3'h0;
  logic [1:0]        fm_r = 2'h0;
  logic              sample_valid_i = 1'b0;
  logic [WORD_W-1:0] ch1_sample_i = '0;
  logic [WORD_W-1:0] ch2_sample_i = '0;
  logic [7:0]        device_status_o;
  logic              shutdown_done_o;
  logic              adc_on_o;
  logic              mic_bias_supply_on_o;
  logic              pll_on_o;
  logic              vol_ramp_o;
  logic              bit_clk;
  logic              frame_sync;
  logic              sdout_o;
  logic              sdout_oe_o;
  logic              go = 1'b0;
  logic              i2s = 1'b0;
  logic [63:0]       frame;
  logic [63:0]       oe_map;
  int                n_oe;
  logic              oe_after;
  logic              done;
  int                n_mismatch = 0;
  int                n_compared = 0;
  int                n_cyc = 0;
  int                n;

  always #20 core_clk_i = ~core_clk_i;

  swps_top #(.INIT_CYC(INIT), .WAKE_CYC(WAKE), .SHUT_CYC(SHUT)) i_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .sleep_ctrl_wr_i(sleep_ctrl_wr_i), .sleep_mode_i(sleep_mode_i),
    .cfg_wr_i(cfg_wr_i), .input_channel_enable_i(ie_r), .output_slot_enable_i(se_r),
    .power_up_control_i(pw_r), .serial_format_i(fm_r), .sample_valid_i(sample_valid_i),
    .ch1_sample_i(ch1_sample_i), .ch2_sample_i(ch2_sample_i), .device_status_o(device_status_o),
    .shutdown_done_o(shutdown_done_o), .adc_on_o(adc_on_o), .mic_bias_supply_on_o(mic_bias_supply_on_o),
    .pll_on_o(pll_on_o), .vol_ramp_o(vol_ramp_o), .bit_clk_i(bit_clk), .frame_sync_i(frame_sync),
    .sdout_o(sdout_o), .sdout_oe_o(sdout_oe_o));

  swps_host_link_model i_host (
    .go_i(go), .i2s_i(i2s), .sdout_i(sdout_o), .sdout_oe_i(sdout_oe_o), .bit_clk_o(bit_clk),
    .frame_sync_o(frame_sync), .frame_o(frame), .oe_map_o(oe_map), .n_oe_o(n_oe), .oe_after_o(oe_after),
    .done_o(done));

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == 5000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic wr_sleep(input logic m);
    @(posedge core_clk_i);
    sleep_ctrl_wr_i <= 1'b1;
    sleep_mode_i    <= m;
    @(posedge core_clk_i);
    sleep_ctrl_wr_i <= 1'b0;
  endtask

  task automatic run_frame;
    @(posedge core_clk_i);
    go <= 1'b1;
    @(posedge core_clk_i);
    go <= 1'b0;
    @(done);
    @(negedge core_clk_i);
  endtask

  // Counts cycles until awake (sel 0) or shutdown done (sel 1)
  task automatic wait_hi(input int sel, output int cnt);
    cnt = 0;
    while (!(sel == 0 ? device_status_o[0] === 1'b1 : shutdown_done_o === 1'b1) && cnt < 1000) begin
      @(negedge core_clk_i);
      cnt++;
    end
  endtask

  task automatic t_record(input bit wr, input logic [1:0] ie, se, fm, input logic [2:0] pw,
                          input logic [WORD_W-1:0] a, b);
    logic [FRAME_W-1:0] ex;
    logic [FRAME_W-1:0] mk;
    ex = {a & {WORD_W{ie[0]}}, b & {WORD_W{ie[1]}}};
    mk = {{WORD_W{se[0]}}, {WORD_W{se[1]}}};
    if (wr) begin
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b1;
      ie_r     <= ie;
      se_r     <= se;
      pw_r     <= pw;
      fm_r     <= fm;
      @(posedge core_clk_i);
      cfg_wr_i <= 1'b0;
    end
    @(posedge core_clk_i);
    sample_valid_i <= 1'b1;
    ch1_sample_i   <= a;
    ch2_sample_i   <= b;
    i2s            <= (fm == FMT_I2S);
    @(posedge core_clk_i);
    sample_valid_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    run_frame();
    `CHK("power", pw, {pll_on_o, mic_bias_supply_on_o, adc_on_o})
    `CHK("frame", ex & mk, frame & mk)
    `CHK("oe_bits", 32 * (int'(se[0]) + int'(se[1])), n_oe)
    `CHK("oe_map", mk, oe_map)
    `CHK("oe_end", 1'b0, oe_after)
  endtask

  task automatic t_sleep;
    wr_sleep(1'b1);
    repeat (2) @(negedge core_clk_i);
    `CHK("pwr_off", 3'h0, {pll_on_o, mic_bias_supply_on_o, adc_on_o})
    `CHK("ramp", 1'b1, vol_ramp_o)
    `CHK("done_early", 1'b0, shutdown_done_o)
    wait_hi(1, n);
    `CHK("shut_time", 1'b1, (n >= SHUT - 3 && n <= SHUT + 4))
    `CHK("ramp_end", 1'b0, vol_ramp_o)
    `CHK("status_sleep", 8'h80, device_status_o)
    run_frame();
    `CHK("oe_asleep", 0, n_oe)
  endtask

  task automatic t_wake(input logic [2:0] pw);
    wr_sleep(1'b0);
    wait_hi(0, n);
    `CHK("wake_time", 1'b1, (n >= WAKE - 2 && n <= WAKE + 4))
    `CHK("status_awake", 8'h01, device_status_o)
    `CHK("pwr_kept", pw, {pll_on_o, mic_bias_supply_on_o, adc_on_o})
  endtask

  initial begin
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    wait_hi(1, n);
    `CHK("init_time", 1'b1, (n >= INIT - 2 && n <= INIT + 4))
    `CHK("status_init", 8'h80, device_status_o)
    `CHK("pwr_init", 4'h0, {vol_ramp_o, pll_on_o, mic_bias_supply_on_o, adc_on_o})
    run_frame();
    `CHK("oe_init", 0, n_oe)
    `CHK("sdo_init", 64'h0, frame)
    t_wake(3'h0);
    t_record(1'b1, 2'b11, 2'b11, FMT_TDM, 3'h7, 32'h8000_0001, 32'h5a5a_a5a5);
    t_record(1'b1, 2'b10, 2'b01, FMT_LJ, 3'h3, 32'hffff_0000, 32'h1234_5678);
    t_record(1'b1, 2'b11, 2'b10, FMT_I2S, 3'h5, 32'h0f0f_0f0f, 32'hc000_0003);
    t_sleep();
    t_wake(3'h5);
    t_record(1'b0, 2'b11, 2'b10, FMT_I2S, 3'h5, 32'h1111_2222, 32'h8765_4321);
    print_verdict();
  end
endmodule
`default_nettype wire
